// ===== hdl/umfc_pkg.sv
package umfc_pkg;
    // ****************************************
    // bus geometry
    // ****************************************
    localparam int          WB_ADDR_W        = 8;
    localparam int          WB_DATA_W        = 32;
    localparam int          REG_W            = 8;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0]  ADDR_FIFO_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_LINE_CTRL   = 8'h04;
    localparam logic [7:0]  ADDR_ENH_FEAT    = 8'h08;
    localparam logic [7:0]  ADDR_ADD_CTRL    = 8'h0C;
    localparam logic [7:0]  ADDR_MODE_STAT   = 8'h10;
    localparam logic [7:0]  ADDR_ADD_STAT    = 8'h14;
    localparam logic [7:0]  ADDR_RX_FILL     = 8'h18;
    localparam logic [7:0]  ADDR_TX_FILL     = 8'h1C;
    localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h20;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h24;
    localparam logic [7:0]  ADDR_SOFT_RST    = 8'h28;
    localparam logic [7:0]  ADDR_IDX_BASE    = 8'h40;
    // indexed control set: byte address = base + 4 * index
    localparam logic [3:0]  IDX_PRESCALER    = 4'h1;
    localparam logic [3:0]  IDX_CLK_SELECT   = 4'h2;
    localparam logic [3:0]  IDX_OVERSAMPLE   = 4'h3;
    localparam logic [3:0]  IDX_RX_TRIG      = 4'h4;
    localparam logic [3:0]  IDX_TX_TRIG      = 4'h5;
    localparam logic [3:0]  IDX_FLOW_LOW     = 4'h6;
    localparam logic [3:0]  IDX_FLOW_HIGH    = 4'h7;
    // ****************************************
    // field positions
    // ****************************************
    localparam int          FCR_ENABLE_BIT   = 0;
    localparam int          FCR_FLUSH_RX_BIT = 1;
    localparam int          FCR_FLUSH_TX_BIT = 2;
    localparam int          FCR_LARGE_BIT    = 5;
    localparam int          LCR_DLAB_BIT     = 7;
    localparam int          EFR_ENH_BIT      = 4;
    localparam int          ACR_RX_DIS_BIT   = 0;
    localparam int          ACR_TX_DIS_BIT   = 1;
    localparam int          ACR_DSR_DTR_BIT  = 2;
    localparam int          ACR_RS485_BIT    = 3;
    localparam int          ACR_NINE_BIT     = 4;
    localparam int          ACR_ARB_TRIG_BIT = 5;
    localparam int          CKS_RX_EXT_BIT   = 0;
    localparam int          CKS_TX_EXT_BIT   = 1;
    localparam int          CKS_TX_OUT_BIT   = 2;
    localparam int          IRQ_DEPTH_BIT    = 0;
    localparam int          IRQ_GUARD_BIT    = 1;
    localparam int          IRQ_W            = 2;
    // ****************************************
    // reset values and figures
    // ****************************************
    localparam logic [7:0]  FCR_RESET        = 8'h00;
    localparam logic [7:0]  CPR_RESET        = 8'h20;   // m = 4, n = 0
    localparam logic [7:0]  TCR_RESET        = 8'h00;
    localparam logic [7:0]  REG_ZERO         = 8'h00;
    localparam logic [8:0]  PRESC_STEP       = 9'h008;  // eighths per clock
    localparam logic [7:0]  DEPTH_BYTE       = 8'h01;
    localparam logic [7:0]  DEPTH_COMPAT     = 8'h10;
    localparam logic [7:0]  DEPTH_DEEP       = 8'h80;
    localparam logic [3:0]  OVS_MIN          = 4'h4;
    localparam logic [4:0]  OVS_DEFAULT      = 5'h10;
    // legacy trigger levels selected by a two-bit field
    localparam logic [7:0]  TRIG_LVL0        = 8'h01;
    localparam logic [7:0]  TRIG_LVL1        = 8'h20;
    localparam logic [7:0]  TRIG_LVL2        = 8'h40;
    localparam logic [7:0]  TRIG_LVL3        = 8'h70;

    typedef enum logic [2:0] {
        MODE_BYTE     = 3'b000,
        MODE_COMPAT16 = 3'b001,
        MODE_PIN_DEEP = 3'b010,
        MODE_LEGACY   = 3'b011,
        MODE_ENHANCED = 3'b100
    } umfc_mode_type;
endpackage

// ===== hdl/umfc_top.sv
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
// What this block does
// R1: reset clears fifo enable, byte mode.
// R2: fifo enable clear forces depth one.
// R3: fifo enable alone gives depth sixteen.
// R4: select pin high gives depth 128.
// R5: large bit gives 128, written only under dlab.
// R6: software sets dlab before writing large bit.
// R7: legacy extras only outside enhanced mode.
// R8: enhanced with fifo enabled gives 128.
// R9: enhanced mode enables its feature set.
// R10: extended features via additional control, enhanced only.
// R11: arbitrary trigger bit selects dedicated threshold registers.
// R12: fill levels and flow status readable.
// R13: extended mode features incl readable fifo control.
// R14: prescaler divides by m plus n/8.
// R15: prescaler resets to divide by four.
// R16: external clocks on ring and dsr, dtr out.
// R17: oversampling resets 16, below four means 16.
// R18: fifo control write keeps large bit without dlab.
module umfc_top
    import umfc_pkg::*;
#(
    parameter int DEPTH_W = 8
) (
    input  wire logic                 CLOCK_I,
    input  wire logic                 RST_N_I,
    input  wire logic                 WB_CYC_I,
    input  wire logic                 WB_STB_I,
    input  wire logic                 WB_WE_I,
    input  wire logic [WB_ADDR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]           WB_SEL_I,
    input  wire logic [WB_DATA_W-1:0] WB_DAT_I,
    output logic      [WB_DATA_W-1:0] WB_DAT_O,
    output logic                      WB_ACK_O,
    output logic                      IRQ_O,
    input  wire logic                 FIFO_SEL_PIN_I,
    input  wire logic [7:0]           RX_FILL_I,
    input  wire logic [7:0]           TX_FILL_I,
    input  wire logic                 LOCAL_TX_FLOW_OFF_I,
    input  wire logic                 REMOTE_TX_FLOW_OFF_I,
    input  wire logic                 RI_CLK_I,
    input  wire logic                 DSR_CLK_I,
    output logic      [DEPTH_W-1:0]   FIFO_DEPTH_O,
    output logic      [2:0]           MODE_O,
    output logic                      AUTO_RTS_CTS_EN_O,
    output logic                      SLEEP_EN_O,
    output logic                      XON_XOFF_EN_O,
    output logic                      SPECIAL_CHAR_EN_O,
    output logic                      IRDA_EN_O,
    output logic                      TX_TRIG_EN_O,
    output logic                      RX_DISABLE_O,
    output logic                      TX_DISABLE_O,
    output logic                      DSR_DTR_FLOW_O,
    output logic                      RS485_EN_O,
    output logic                      NINE_BIT_O,
    output logic                      SOFT_RESET_O,
    output logic                      FLUSH_RX_O,
    output logic                      FLUSH_TX_O,
    output logic      [7:0]           RX_TRIG_O,
    output logic      [7:0]           TX_TRIG_O,
    output logic      [7:0]           FLOW_LOW_O,
    output logic      [7:0]           FLOW_HIGH_O,
    output logic      [4:0]           SAMPLES_O,
    output logic                      BAUD_TICK_O,
    output logic                      RX_CLK_TICK_O,
    output logic                      TX_CLK_TICK_O,
    output logic                      DTR_CLK_O,
    output logic                      DTR_CLK_OE_O
);
    if (DEPTH_W < 8) begin : g_depth_check
        $error("DEPTH_W must hold 128");
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] legacy_trig(input logic [1:0] code);
        case (code)
            2'b00:   legacy_trig = TRIG_LVL0;
            2'b01:   legacy_trig = TRIG_LVL1;
            2'b10:   legacy_trig = TRIG_LVL2;
            default: legacy_trig = TRIG_LVL3;
        endcase
    endfunction
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]        fcr_q;
    logic [7:0]        lcr_q;
    logic [7:0]        efr_q;
    logic [7:0]        acr_q;
    logic [7:0]        cpr_q;
    logic [7:0]        cks_q;
    logic [7:0]        tcr_q;
    logic [7:0]        rtl_q;
    logic [7:0]        ttl_q;
    logic [7:0]        fcl_q;
    logic [7:0]        fch_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              ack_q;
    logic [7:0]        rdat_q;
    logic              soft_rst_q;
    logic              flush_rx_q;
    logic              flush_tx_q;
    logic [8:0]        acc_q;
    logic              tick_q;
    logic              ri_q;
    logic              dsr_q;
    logic [7:0]        depth_q;
    // ****************************************
    // bus decode
    // ****************************************
    wire req        = WB_CYC_I & WB_STB_I;
    wire lane0      = WB_SEL_I[0];
    wire wr         = req & ack_q & WB_WE_I & lane0;
    wire is_idx     = WB_ADR_I[7:6] == ADDR_IDX_BASE[7:6];
    wire [3:0] idx  = WB_ADR_I[5:2];
    wire wr_fcr     = wr & (WB_ADR_I == ADDR_FIFO_CTRL);
    wire wr_lcr     = wr & (WB_ADR_I == ADDR_LINE_CTRL);
    wire wr_efr     = wr & (WB_ADR_I == ADDR_ENH_FEAT);
    wire wr_acr     = wr & (WB_ADR_I == ADDR_ADD_CTRL);
    wire wr_istat   = wr & (WB_ADR_I == ADDR_IRQ_STAT);
    wire wr_imask   = wr & (WB_ADR_I == ADDR_IRQ_MASK);
    wire wr_srst    = wr & (WB_ADR_I == ADDR_SOFT_RST);
    wire wr_idx     = wr & is_idx & (WB_ADR_I[1:0] == 2'b00);
    wire [7:0] wd   = WB_DAT_I[7:0];
    // ****************************************
    // mode selection
    // ****************************************
    wire fifo_en    = fcr_q[FCR_ENABLE_BIT];
    wire enhanced   = efr_q[EFR_ENH_BIT];
    wire dlab       = lcr_q[LCR_DLAB_BIT];
    wire large_bit  = fcr_q[FCR_LARGE_BIT];
    umfc_mode_type mode;
    always_comb begin
        if (!fifo_en) begin
            mode = MODE_BYTE;                               // see R2
        end else if (enhanced) begin
            mode = MODE_ENHANCED;                           // see R8
        end else if (FIFO_SEL_PIN_I) begin
            mode = MODE_PIN_DEEP;                           // see R4
        end else if (large_bit) begin
            mode = MODE_LEGACY;                             // see R5
        end else begin
            mode = MODE_COMPAT16;                           // see R3
        end
    end
    wire [7:0] depth = (mode == MODE_BYTE)     ? DEPTH_BYTE
                     : (mode == MODE_COMPAT16) ? DEPTH_COMPAT : DEPTH_DEEP;
    // large bit written while the guard is up: refused
    wire guard_refused = wr_fcr & ~dlab & (wd[FCR_LARGE_BIT] != large_bit);
    wire depth_changed = depth != depth_q;
    // ****************************************
    // feature gating
    // ****************************************
    wire legacy_ext = fifo_en & ~enhanced;
    wire [7:0] acr_eff = enhanced ? acr_q : REG_ZERO;       // see R10
    wire arb_trig   = acr_eff[ACR_ARB_TRIG_BIT];
    assign FIFO_DEPTH_O      = DEPTH_W'(depth);
    assign MODE_O            = mode;
    assign AUTO_RTS_CTS_EN_O = legacy_ext;                  // see R7
    assign SLEEP_EN_O        = legacy_ext | enhanced;       // see R7 see R9
    assign XON_XOFF_EN_O     = enhanced;                    // see R9
    assign SPECIAL_CHAR_EN_O = enhanced;                    // see R9
    assign IRDA_EN_O         = enhanced;                    // see R9
    assign TX_TRIG_EN_O      = enhanced;                    // see R9
    assign RX_DISABLE_O      = acr_eff[ACR_RX_DIS_BIT];     // see R13
    assign TX_DISABLE_O      = acr_eff[ACR_TX_DIS_BIT];     // see R13
    assign DSR_DTR_FLOW_O    = acr_eff[ACR_DSR_DTR_BIT];    // see R13
    assign RS485_EN_O        = acr_eff[ACR_RS485_BIT];      // see R13
    assign NINE_BIT_O        = acr_eff[ACR_NINE_BIT];       // see R13
    assign SOFT_RESET_O      = soft_rst_q;
    assign FLUSH_RX_O        = flush_rx_q;
    assign FLUSH_TX_O        = flush_tx_q;
    assign RX_TRIG_O   = arb_trig ? rtl_q : legacy_trig(fcr_q[7:6]);   // see R11
    assign TX_TRIG_O   = arb_trig ? ttl_q : legacy_trig(fcr_q[5:4]);   // see R11
    assign FLOW_LOW_O  = arb_trig ? fcl_q : legacy_trig(fcr_q[7:6]);   // see R11
    assign FLOW_HIGH_O = arb_trig ? fch_q : legacy_trig(fcr_q[7:6]);   // see R11
    assign SAMPLES_O   = (tcr_q[3:0] < OVS_MIN) ? OVS_DEFAULT : {1'b0, tcr_q[3:0]};  // see R17
    // ****************************************
    // fractional prescaler, counted in eighths
    // ****************************************
    wire [8:0] div_8  = (cpr_q[7:3] == 5'h00) ? PRESC_STEP : {1'b0, cpr_q};  // see R14
    wire [8:0] acc_up = acc_q + PRESC_STEP;
    wire       hit    = acc_up >= div_8;
    wire [8:0] acc_d  = hit ? 9'(acc_up - div_8) : acc_up;
    wire       use_pre = enhanced;                          // see R9
    assign BAUD_TICK_O = use_pre ? tick_q : 1'b1;
    // ****************************************
    // external clocks
    // ****************************************
    wire ri_rise  = RI_CLK_I & ~ri_q;
    wire dsr_rise = DSR_CLK_I & ~dsr_q;
    assign TX_CLK_TICK_O = cks_q[CKS_TX_EXT_BIT] ? ri_rise : BAUD_TICK_O;   // see R16
    assign RX_CLK_TICK_O = cks_q[CKS_RX_EXT_BIT] ? dsr_rise : BAUD_TICK_O;  // see R16
    assign DTR_CLK_O     = cks_q[CKS_TX_OUT_BIT] & tick_q;                  // see R16
    assign DTR_CLK_OE_O  = cks_q[CKS_TX_OUT_BIT];
    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] rmux;
    always_comb begin
        rmux = REG_ZERO;
        if (is_idx) begin
            case (idx)
                IDX_PRESCALER:  rmux = cpr_q;
                IDX_CLK_SELECT: rmux = cks_q;
                IDX_OVERSAMPLE: rmux = tcr_q;
                IDX_RX_TRIG:    rmux = rtl_q;
                IDX_TX_TRIG:    rmux = ttl_q;
                IDX_FLOW_LOW:   rmux = fcl_q;
                IDX_FLOW_HIGH:  rmux = fch_q;
                default:        rmux = REG_ZERO;
            endcase
        end else begin
            case (WB_ADR_I)
                ADDR_FIFO_CTRL: rmux = enhanced ? fcr_q : REG_ZERO;      // see R13
                ADDR_LINE_CTRL: rmux = lcr_q;
                ADDR_ENH_FEAT:  rmux = efr_q;
                ADDR_ADD_CTRL:  rmux = acr_q;
                ADDR_MODE_STAT: rmux = {5'h00, mode};
                ADDR_ADD_STAT:  rmux = {6'h00, REMOTE_TX_FLOW_OFF_I,
                                        LOCAL_TX_FLOW_OFF_I};            // see R12
                ADDR_RX_FILL:   rmux = RX_FILL_I;                        // see R12
                ADDR_TX_FILL:   rmux = TX_FILL_I;                        // see R12
                ADDR_IRQ_STAT:  rmux = {6'h00, irq_stat_q};
                ADDR_IRQ_MASK:  rmux = {6'h00, irq_mask_q};
                default:        rmux = REG_ZERO;
            endcase
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = {24'h00_0000, rdat_q};
    assign IRQ_O    = |(irq_stat_q & irq_mask_q);
    // ****************************************
    // bus handshake
    // ****************************************
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            ack_q  <= 1'b0;
            rdat_q <= REG_ZERO;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdat_q <= rmux;
            end
        end
    end
    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            fcr_q <= FCR_RESET;                             // see R1
        end else if (wr_fcr) begin
            fcr_q <= {wd[7:6], dlab ? wd[FCR_LARGE_BIT] : large_bit,
                      wd[4:0]};                             // see R5 see R18
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            lcr_q <= REG_ZERO;
            efr_q <= REG_ZERO;
            acr_q <= REG_ZERO;
        end else begin
            if (wr_lcr) lcr_q <= wd;
            if (wr_efr) efr_q <= wd;
            if (wr_acr) acr_q <= wd;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            cpr_q <= CPR_RESET;                             // see R15
            cks_q <= REG_ZERO;
            tcr_q <= TCR_RESET;                             // see R17
            rtl_q <= REG_ZERO;
            ttl_q <= REG_ZERO;
            fcl_q <= REG_ZERO;
            fch_q <= REG_ZERO;
        end else if (wr_idx) begin
            case (idx)
                IDX_PRESCALER:  cpr_q <= wd;
                IDX_CLK_SELECT: cks_q <= wd;
                IDX_OVERSAMPLE: tcr_q <= wd;
                IDX_RX_TRIG:    rtl_q <= wd;
                IDX_TX_TRIG:    ttl_q <= wd;
                IDX_FLOW_LOW:   fcl_q <= wd;
                IDX_FLOW_HIGH:  fch_q <= wd;
                default:        cpr_q <= cpr_q;
            endcase
        end
    end
    // ****************************************
    // pulses, prescaler, edges, interrupts
    // ****************************************
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            soft_rst_q <= 1'b0;
            flush_rx_q <= 1'b0;
            flush_tx_q <= 1'b0;
            acc_q      <= 9'h000;
            tick_q     <= 1'b0;
            ri_q       <= 1'b0;
            dsr_q      <= 1'b0;
            depth_q    <= DEPTH_BYTE;
        end else begin
            soft_rst_q <= wr_srst & enhanced & wd[0];       // see R13
            flush_rx_q <= wr_fcr & wd[FCR_FLUSH_RX_BIT];
            flush_tx_q <= wr_fcr & wd[FCR_FLUSH_TX_BIT];
            acc_q      <= acc_d;                            // see R14
            tick_q     <= hit;
            ri_q       <= RI_CLK_I;
            dsr_q      <= DSR_CLK_I;
            depth_q    <= depth;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_istat ? wd[IRQ_W-1:0] : '0))
                        | {guard_refused, depth_changed};
            if (wr_imask) irq_mask_q <= wd[IRQ_W-1:0];
        end
    end
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    property p_reset_byte;
        $rose(RST_N_I) |-> depth == DEPTH_BYTE && !fifo_en;
    endproperty
    a_reset_byte: assert property (p_reset_byte)               // see R1
        else $error("fifo not disabled after reset");
    property p_byte_depth;
        !fifo_en |-> FIFO_DEPTH_O == DEPTH_W'(DEPTH_BYTE) && mode == MODE_BYTE;
    endproperty
    a_byte_depth: assert property (p_byte_depth)               // see R2
        else $error("depth not one with fifo disabled");
    property p_compat;
        fifo_en && !enhanced && !FIFO_SEL_PIN_I && !large_bit
            |-> depth == DEPTH_COMPAT;
    endproperty
    a_compat: assert property (p_compat)                       // see R3
        else $error("depth not sixteen");
    property p_deep;
        fifo_en && (enhanced || FIFO_SEL_PIN_I || large_bit) |-> depth == DEPTH_DEEP;
    endproperty
    a_deep: assert property (p_deep)                           // see R4
        else $error("depth not 128");
    property p_guard;
        wr_fcr && !dlab |=> fcr_q[FCR_LARGE_BIT] == $past(large_bit);
    endproperty
    a_guard: assert property (p_guard)                         // see R18
        else $error("large bit changed without dlab");
    property p_guard_open;
        wr_fcr && dlab |=> fcr_q[FCR_LARGE_BIT] == $past(wd[FCR_LARGE_BIT]);
    endproperty
    a_guard_open: assert property (p_guard_open)               // see R5
        else $error("large bit not written under dlab");
    property p_legacy;
        enhanced |-> !AUTO_RTS_CTS_EN_O && IRDA_EN_O && XON_XOFF_EN_O;
    endproperty
    a_legacy: assert property (p_legacy)                       // see R7
        else $error("feature gating wrong");
    property p_ext_gate;
        !enhanced |-> !RX_DISABLE_O && !NINE_BIT_O && !RS485_EN_O;
    endproperty
    a_ext_gate: assert property (p_ext_gate)                   // see R10
        else $error("extended feature outside enhanced mode");
    property p_arb;
        arb_trig |-> RX_TRIG_O == rtl_q && FLOW_HIGH_O == fch_q;
    endproperty
    a_arb: assert property (p_arb)                             // see R11
        else $error("arbitrary threshold not used");
    property p_ovs;
        tcr_q[3:0] < OVS_MIN |-> SAMPLES_O == OVS_DEFAULT;
    endproperty
    a_ovs: assert property (p_ovs)                             // see R17
        else $error("oversampling default wrong");
    property p_presc_four;
        use_pre && cpr_q == CPR_RESET && tick_q |=> !tick_q [*3] ##1 tick_q;
    endproperty
    a_presc_four: assert property (p_presc_four)               // see R14
        else $error("prescaler not dividing by four");
    property p_ack;
        req && !ack_q |=> ack_q ##1 !ack_q;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not single cycle");
endmodule

// ===== tb/umfc_partner.sv
`timescale 1ns/1ns
module umfc_partner (
    input  wire logic clk_i,
    input  wire logic en_i,
    output logic      ri_clk_o,
    output logic      dsr_clk_o
);
    logic [2:0] div_q;
    // external clocks run only while enabled and idle low otherwise
    always_ff @(posedge clk_i) begin
        div_q <= en_i ? div_q + 3'h1 : 3'h0;
    end
    assign ri_clk_o  = div_q[2];
    assign dsr_clk_o = div_q[2];
endmodule

// ===== tb/umfc_top_bench.sv
`timescale 1ns/1ns
module umfc_top_bench;
    import umfc_pkg::*;
    logic        clk, rst_n, cyc, stb, we, pin, ext_en, ack, irq, rxt, ri, dsr, rts, xon;
    logic        txt, btk, dtr, oe;
    logic [7:0]  adr, rd, depth, rfill, rtrig;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [2:0]  mode;
    logic [4:0]  smp;
    int          num_errors, num_checks, cycles, cnt, tcnt, bcnt, dcnt;
    umfc_top i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ_O(irq), .FIFO_SEL_PIN_I(pin), .RX_FILL_I(rfill),
        .TX_FILL_I(8'h00), .LOCAL_TX_FLOW_OFF_I(1'b0), .REMOTE_TX_FLOW_OFF_I(1'b1),
        .RI_CLK_I(ri), .DSR_CLK_I(dsr), .FIFO_DEPTH_O(depth), .MODE_O(mode),
        .AUTO_RTS_CTS_EN_O(rts), .SLEEP_EN_O(), .XON_XOFF_EN_O(xon),
        .SPECIAL_CHAR_EN_O(), .IRDA_EN_O(), .TX_TRIG_EN_O(), .RX_DISABLE_O(),
        .TX_DISABLE_O(), .DSR_DTR_FLOW_O(), .RS485_EN_O(), .NINE_BIT_O(),
        .SOFT_RESET_O(), .FLUSH_RX_O(), .FLUSH_TX_O(), .RX_TRIG_O(rtrig), .TX_TRIG_O(),
        .FLOW_LOW_O(), .FLOW_HIGH_O(), .SAMPLES_O(smp), .BAUD_TICK_O(btk),
        .RX_CLK_TICK_O(rxt), .TX_CLK_TICK_O(txt), .DTR_CLK_O(dtr), .DTR_CLK_OE_O(oe));
    umfc_partner i_far (.clk_i(clk), .en_i(ext_en), .ri_clk_o(ri), .dsr_clk_o(dsr));
    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, {24'h00_0000, e}, {24'h00_0000, rd});
    endtask
    task automatic t_reset();
        rdchk("mode", ADDR_MODE_STAT, 8'h00);
        rdchk("prescaler", 8'h44, 8'h20);
        rdchk("oversampling", 8'h4C, 8'h00);
        chk("samples", 32'h0000_0010, {27'h0, smp});
        rdchk("unmapped", 8'h3C, 8'h00);
    endtask
    task automatic t_depth();
        wb(1'b1, ADDR_IRQ_MASK, 8'h03);
        wb(1'b1, ADDR_FIFO_CTRL, 8'h01);
        @(negedge clk);
        chk("depth16", 32'h0000_0010, {24'h0, depth});
        @(negedge clk);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        @(posedge clk) pin <= 1'b1;
        @(negedge clk);
        chk("depth pin", 32'h0000_0080, {24'h0, depth});
        @(posedge clk) pin <= 1'b0;
        wb(1'b1, ADDR_IRQ_STAT, 8'h03);
        @(negedge clk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        wb(1'b1, ADDR_FIFO_CTRL, 8'h21);
        rdchk("guard irq", ADDR_IRQ_STAT, 8'h02);
        chk("depth kept", 32'h0000_0010, {24'h0, depth});
        wb(1'b1, ADDR_IRQ_STAT, 8'h02);
        wb(1'b1, ADDR_LINE_CTRL, 8'h80);
        wb(1'b1, ADDR_FIFO_CTRL, 8'h21);
        wb(1'b1, ADDR_LINE_CTRL, 8'h00);
        chk("depth large", 32'h0000_0080, {24'h0, depth});
        chk("mode large", 32'h0000_0003, {29'h0, mode});
        wb(1'b1, ADDR_FIFO_CTRL, 8'h20);
        @(posedge clk) pin <= 1'b1;
        @(negedge clk);
        chk("depth byte", 32'h0000_0001, {24'h0, depth});
        wb(1'b1, ADDR_IRQ_MASK, 8'h00);
        @(negedge clk);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
    endtask
    task automatic t_enh();
        wb(1'b1, ADDR_ENH_FEAT, 8'h10);
        wb(1'b1, ADDR_FIFO_CTRL, 8'h01);
        @(negedge clk);
        chk("depth enh", 32'h0000_0080, {24'h0, depth});
        chk("rts cts", 32'h0000_0000, {31'h0, rts});
        chk("xon", 32'h0000_0001, {31'h0, xon});
        rdchk("fifo ctrl", ADDR_FIFO_CTRL, 8'h21);
        wb(1'b1, ADDR_ADD_CTRL, 8'h20);
        wb(1'b1, 8'h50, 8'h33);
        @(negedge clk);
        chk("rx trig", 32'h0000_0033, {24'h0, rtrig});
        wb(1'b1, 8'h4C, 8'h0D);
        @(negedge clk);
        chk("samples13", 32'h0000_000D, {27'h0, smp});
        wb(1'b1, 8'h4C, 8'h03);
        @(negedge clk);
        chk("samples3", 32'h0000_0010, {27'h0, smp});
        @(posedge clk) rfill <= 8'h5A;
        rdchk("rx fill", ADDR_RX_FILL, 8'h5A);
        rdchk("flow stat", ADDR_ADD_STAT, 8'h02);
    endtask
    task automatic t_ext();
        wb(1'b1, 8'h48, 8'h07);
        ext_en <= 1'b1;
        repeat (16) @(posedge clk);
        cnt = 0;
        tcnt = 0;
        bcnt = 0;
        dcnt = 0;
        repeat (80) @(negedge clk) begin
            cnt += (rxt === 1'b1);
            tcnt += (txt === 1'b1);
            bcnt += (btk === 1'b1);
            dcnt += (dtr === 1'b1);
        end
        chk("rx ext ticks", 32'h0000_000A, 32'(cnt));
        chk("tx ext ticks", 32'h0000_000A, 32'(tcnt));
        chk("baud ticks", 32'h0000_0014, 32'(bcnt));
        chk("dtr ticks", 32'h0000_0014, 32'(dcnt));
        chk("dtr enable", 32'h0000_0001, {31'h0, oe});
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, cyc, stb, we, pin, ext_en} = 6'h00;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        rfill = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_depth();
        t_enh();
        t_ext();
        report_and_stop();
    end
endmodule
